// ===== hw/npi_pkg.sv
// Constants, types and register map of the nested priority interrupt unit
`default_nettype none

package npi_pkg;
    localparam int NSRC = 7;
    localparam int NEXT = 4;
    localparam int AW = 6;
    localparam int DW = 16;
    localparam int KW = 6;
    // Source index order is also the tie-break order
    localparam int SRC_TMR = 0;
    localparam int SRC_DMA0 = 1;
    localparam int SRC_DMA1 = 2;
    localparam int SRC_EXA = 3;
    localparam int SRC_EXB = 4;
    localparam int SRC_EXC = 5;
    localparam int SRC_EXD = 6;
    localparam logic [AW-1:0] OFS_EOI = 6'h00;
    localparam logic [AW-1:0] OFS_POLL = 6'h04;
    localparam logic [AW-1:0] OFS_PSTAT = 6'h08;
    localparam logic [AW-1:0] OFS_MASK = 6'h0C;
    localparam logic [AW-1:0] OFS_INSV = 6'h10;
    localparam logic [AW-1:0] OFS_REQ = 6'h14;
    localparam logic [AW-1:0] OFS_RELOC = 6'h18;
    localparam logic [AW-1:0] OFS_CTL0 = 6'h20;
    localparam int EOI_NONSPEC = 15;
    localparam int POLL_VALID = 15;
    localparam int RELOC_SLAVE = 14;
    localparam int VW = 5;
    // Writable control bits per source kind
    localparam logic [6:0] CTL_WM_INT = 7'h0F;
    localparam logic [6:0] CTL_WM_CD = 7'h1F;
    localparam logic [6:0] CTL_WM_AB = 7'h7F;
    localparam logic [6:0] CTL_RESET = 7'h0F;
    localparam logic [7:0] VEC_SPURIOUS = 8'h07;
    localparam logic [VW-1:0] VEC_TAB [NSRC] = '{
        5'h08, 5'h0A, 5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F};

    typedef struct packed {
        logic special_nested_bit;
        logic cas;
        logic trigger_mode_bit;
        logic msk;
        logic [2:0] pri;
    } npi_ctl_s;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic wr;
        logic rd;
    } npi_bus_s;

    typedef enum logic {ST_IDLE, ST_CASC} npi_state_e;
endpackage

`default_nettype wire

// ===== hw/npi_unit.sv
// Nested priority interrupt unit, master mode, with register port
`default_nettype none

module npi_unit (
    input wire logic clock,
    input wire logic rst,
    input wire npi_pkg::npi_bus_s bus,
    output logic [npi_pkg::DW-1:0] rdata,
    input wire logic [2:0] timer_irq,
    input wire logic [1:0] dma_irq,
    input wire logic ext_request_a,
    input wire logic ext_request_b,
    input wire logic ext_request_c_or_ack_a_in,
    output logic ext_request_c_or_ack_a_out,
    output logic ext_request_c_or_ack_a_oe,
    input wire logic ext_request_d_or_ack_b_in,
    output logic ext_request_d_or_ack_b_out,
    output logic ext_request_d_or_ack_b_oe,
    input wire logic nmi_pin,
    input wire logic [7:0] ext_vector,
    input wire logic acknowledge_cycle,
    output logic cpu_intr,
    output logic cpu_nmi,
    output logic vec_valid,
    output logic [7:0] vec_type
);
    localparam int N = npi_pkg::NSRC;
    localparam int KW = npi_pkg::KW;

    ////////////////////////////////////////////////////////////////////
    // Functions

    function automatic logic [2:0] idx3(input int i);
        return 3'(i);
    endfunction

    // Lowest key wins: level first, then fixed source order
    function automatic logic [3:0] pick(input logic [N-1:0] cand,
                                        input logic [N*KW-1:0] keys);
        logic [3:0] best;
        logic [KW-1:0] bk;
        best = 4'h0;
        bk = 6'h3F;
        for (int i = 0; i < N; i++) begin
            if (cand[i] && (!best[3] || keys[i*KW +: KW] < bk)) begin
                best = {1'b1, idx3(i)};
                bk = keys[i*KW +: KW];
            end
        end
        return best;
    endfunction

    function automatic logic [N-1:0] onehot(input logic [3:0] w);
        logic [N-1:0] v;
        v = '0;
        for (int i = 0; i < N; i++) begin
            v[i] = w[3] && (w[2:0] == idx3(i));
        end
        return v;
    endfunction

    function automatic logic [npi_pkg::AW-1:0] ctl_ofs(input int i);
        return npi_pkg::OFS_CTL0 + npi_pkg::AW'(4 * i);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // State

    npi_pkg::npi_ctl_s ctl_reg [N];
    npi_pkg::npi_ctl_s ctl_next [N];
    npi_pkg::npi_state_e st_reg;
    logic [N-1:0] is_reg;
    logic [N-1:0] is_next;
    logic [2:0] ireq_reg;
    logic [2:0] ireq_next;
    logic [3:0] armed_reg;
    logic [3:0] armed_next;
    logic [3:0] pin_s1_reg;
    logic [3:0] pin_s2_reg;
    logic nmi_s1_reg;
    logic nmi_s2_reg;
    logic [7:0] xv_s1_reg;
    logic [7:0] xv_s2_reg;
    logic slave_reg;
    logic pair_reg;
    logic [npi_pkg::DW-1:0] rdata_reg;
    logic intr_reg;
    logic nmi_reg;
    logic vv_reg;
    logic [7:0] vt_reg;
    logic ack_a_reg;
    logic ack_b_reg;
    logic oe_a_reg;
    logic oe_b_reg;

    ////////////////////////////////////////////////////////////////////
    // Decode and priority

    logic wr_eoi, wr_mask, wr_insv, wr_req, wr_reloc;
    logic rd_poll, rd_pstat;
    assign wr_eoi = bus.wr && bus.addr == npi_pkg::OFS_EOI;
    assign wr_mask = bus.wr && bus.addr == npi_pkg::OFS_MASK;
    assign wr_insv = bus.wr && bus.addr == npi_pkg::OFS_INSV;
    assign wr_req = bus.wr && bus.addr == npi_pkg::OFS_REQ;
    assign wr_reloc = bus.wr && bus.addr == npi_pkg::OFS_RELOC;
    assign rd_poll = bus.rd && bus.addr == npi_pkg::OFS_POLL;
    assign rd_pstat = bus.rd && bus.addr == npi_pkg::OFS_PSTAT;

    logic cas_a, cas_b;
    logic [3:0] lvl;
    logic [3:0] ext_req;
    logic [3:0] ext_en;
    logic [N-1:0] raw_req, msk_v, pend, special_nested_bit_ok, blocked, elig;
    logic [N*KW-1:0] keys;
    logic [3:0] win, isb;
    logic [KW-1:0] win_key, isb_key;

    assign cas_a = ctl_reg[npi_pkg::SRC_EXA].cas;
    assign cas_b = ctl_reg[npi_pkg::SRC_EXB].cas;
    assign lvl = pin_s2_reg;
    // Slave mode stops all external inputs; cascade borrows pins c, d
    assign ext_en = {~cas_b, ~cas_a, 2'b11} & {4{~slave_reg}};

    // Keys passed in, so continuous users re-evaluate on priority writes
    function automatic logic [N-1:0] lower_than(input logic [N*KW-1:0] k,
                                                input int s);
        logic [N-1:0] v;
        v = '0;
        for (int j = 0; j < N; j++) begin
            v[j] = k[j*KW +: KW] <= k[s*KW +: KW];
        end
        return v;
    endfunction

    genvar g;
    generate
        for (g = 0; g < N; g++) begin : g_src
            assign keys[g*KW +: KW] = {ctl_reg[g].pri, idx3(g)};
            assign msk_v[g] = ctl_reg[g].msk;
            assign blocked[g] = |(is_reg & (~special_nested_bit_ok | ~onehot({1'b1,
                idx3(g)})) & lower_than(keys, g));
        end
        for (g = 0; g < 4; g++) begin : g_ext
            assign ext_req[g] = ext_en[g] && lvl[g] &&
                (ctl_reg[npi_pkg::SRC_EXA + g].trigger_mode_bit || armed_reg[g]);
        end
    endgenerate

    assign special_nested_bit_ok = {2'b00, ctl_reg[npi_pkg::SRC_EXB].special_nested_bit,
        ctl_reg[npi_pkg::SRC_EXA].special_nested_bit, 3'b000};
    assign raw_req = {ext_req, ireq_reg};
    assign pend = raw_req & ~msk_v;
    assign elig = pend & ~blocked;
    assign win = pick(elig, keys);
    assign isb = pick(is_reg, keys);
    assign win_key = keys[win[2:0]*KW +: KW];
    assign isb_key = keys[isb[2:0]*KW +: KW];

    logic win_casc;
    assign win_casc = win[3] && ((win[2:0] == idx3(npi_pkg::SRC_EXA) && cas_a)
        || (win[2:0] == idx3(npi_pkg::SRC_EXB) && cas_b));

    ////////////////////////////////////////////////////////////////////
    // Acknowledge, poll and end-of-service

    logic ack_idle, take;
    logic [N-1:0] take_v, eoi_clr, spec_v;
    assign ack_idle = acknowledge_cycle && st_reg == npi_pkg::ST_IDLE;
    assign take = (ack_idle || rd_poll) && win[3];
    assign take_v = take ? onehot(win) : '0;

    generate
        for (g = 0; g < N; g++) begin : g_eoi
            assign spec_v[g] = bus.wdata[npi_pkg::VW-1:0] ==
                npi_pkg::VEC_TAB[g];
        end
    endgenerate
    assign eoi_clr = !wr_eoi ? '0 : bus.wdata[npi_pkg::EOI_NONSPEC] ?
        onehot(isb) : spec_v;

    // A new acknowledge wins over a clear in the same cycle
    assign is_next = ((wr_insv ? bus.wdata[N-1:0] : is_reg) & ~eoi_clr)
        | take_v;
    assign ireq_next = ((wr_req ? bus.wdata[2:0] : ireq_reg) & ~take_v[2:0])
        | {dma_irq, |timer_irq};
    assign armed_next = (armed_reg & ~take_v[N-1:3]) | ~lvl;

    generate
        for (g = 0; g < N; g++) begin : g_ctl
            localparam logic [6:0] WM = g < npi_pkg::SRC_EXA ?
                npi_pkg::CTL_WM_INT : g < npi_pkg::SRC_EXC ?
                npi_pkg::CTL_WM_AB : npi_pkg::CTL_WM_CD;
            always_comb begin
                ctl_next[g] = ctl_reg[g];
                if (bus.wr && bus.addr == ctl_ofs(g)) begin
                    ctl_next[g] = bus.wdata[6:0] & WM;
                end
                if (wr_mask) begin
                    ctl_next[g].msk = bus.wdata[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////
    // Read data

    logic [npi_pkg::DW-1:0] poll_w, rd_mux;
    logic [npi_pkg::DW-1:0] ctl_rd [N];
    assign poll_w = {win[3], 10'h000,
        npi_pkg::VEC_TAB[win[2:0]] & {npi_pkg::VW{win[3]}}};
    generate
        for (g = 0; g < N; g++) begin : g_rd
            assign ctl_rd[g] = bus.addr == ctl_ofs(g) ?
                {9'h000, ctl_reg[g]} : 16'h0000;
        end
    endgenerate

    always_comb begin
        rd_mux = 16'h0000;
        for (int i = 0; i < N; i++) begin
            rd_mux = rd_mux | ctl_rd[i];
        end
        unique case (bus.addr)
            npi_pkg::OFS_POLL, npi_pkg::OFS_PSTAT: rd_mux = poll_w;
            npi_pkg::OFS_MASK: rd_mux = {9'h000, msk_v};
            npi_pkg::OFS_INSV: rd_mux = {9'h000, is_reg};
            npi_pkg::OFS_REQ: rd_mux = {9'h000, raw_req};
            npi_pkg::OFS_RELOC:
                rd_mux = 16'(slave_reg) << npi_pkg::RELOC_SLAVE;
            default: rd_mux = rd_mux;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pin_s1_reg <= 4'h0;
            pin_s2_reg <= 4'h0;
            nmi_s1_reg <= 1'b0;
            nmi_s2_reg <= 1'b0;
            xv_s1_reg <= 8'h00;
            xv_s2_reg <= 8'h00;
        end else begin
            pin_s1_reg <= {ext_request_d_or_ack_b_in,
                ext_request_c_or_ack_a_in, ext_request_b, ext_request_a};
            pin_s2_reg <= pin_s1_reg;
            nmi_s1_reg <= nmi_pin;
            nmi_s2_reg <= nmi_s1_reg;
            xv_s1_reg <= ext_vector;
            xv_s2_reg <= xv_s1_reg;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                ctl_reg[i] <= npi_pkg::CTL_RESET;
            end
            is_reg <= '0;
            ireq_reg <= 3'h0;
            armed_reg <= 4'h0;
            slave_reg <= 1'b0;
        end else begin
            for (int i = 0; i < N; i++) begin
                ctl_reg[i] <= ctl_next[i];
            end
            is_reg <= is_next;
            ireq_reg <= ireq_next;
            armed_reg <= armed_next;
            if (wr_reloc) begin
                slave_reg <= bus.wdata[npi_pkg::RELOC_SLAVE];
            end
        end
    end

    // Cascaded source: first acknowledge drives the pair's pin,
    // second one carries the vector that the far controller put out
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            st_reg <= npi_pkg::ST_IDLE;
            pair_reg <= 1'b0;
            vv_reg <= 1'b0;
            vt_reg <= 8'h00;
            ack_a_reg <= 1'b0;
            ack_b_reg <= 1'b0;
        end else begin
            vv_reg <= 1'b0;
            unique case (st_reg)
                npi_pkg::ST_IDLE: if (acknowledge_cycle) begin
                    if (win_casc) begin
                        st_reg <= npi_pkg::ST_CASC;
                        pair_reg <= win[2:0] == idx3(npi_pkg::SRC_EXA);
                        ack_a_reg <= win[2:0] == idx3(npi_pkg::SRC_EXA);
                        ack_b_reg <= win[2:0] == idx3(npi_pkg::SRC_EXB);
                    end else begin
                        vv_reg <= 1'b1;
                        vt_reg <= win[3] ? 8'(npi_pkg::VEC_TAB[win[2:0]])
                            : npi_pkg::VEC_SPURIOUS;
                    end
                end
                npi_pkg::ST_CASC: if (acknowledge_cycle) begin
                    st_reg <= npi_pkg::ST_IDLE;
                    vv_reg <= 1'b1;
                    vt_reg <= xv_s2_reg;
                    ack_a_reg <= 1'b0;
                    ack_b_reg <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rdata_reg <= 16'h0000;
            intr_reg <= 1'b0;
            nmi_reg <= 1'b0;
            oe_a_reg <= 1'b0;
            oe_b_reg <= 1'b0;
        end else begin
            rdata_reg <= bus.rd ? rd_mux : 16'h0000;
            intr_reg <= win[3];
            nmi_reg <= nmi_s2_reg;
            oe_a_reg <= cas_a && !slave_reg;
            oe_b_reg <= cas_b && !slave_reg;
        end
    end

    assign rdata = rdata_reg;
    assign cpu_intr = intr_reg;
    assign cpu_nmi = nmi_reg;
    assign vec_valid = vv_reg;
    assign vec_type = vt_reg;
    assign ext_request_c_or_ack_a_out = ack_a_reg;
    assign ext_request_c_or_ack_a_oe = oe_a_reg;
    assign ext_request_d_or_ack_b_out = ack_b_reg;
    assign ext_request_d_or_ack_b_oe = oe_b_reg;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    a_intr_tracks_win: assert property (win[3] |=> cpu_intr)
        else $error("request to CPU not raised");
    a_lower_blocked: assert property (win[3] && isb[3] &&
        win[2:0] != isb[2:0] |-> win_key < isb_key)
        else $error("lower priority source forwarded");
    a_own_blocked: assert property (win[3] |->
        !(is_reg[win[2:0]] && !special_nested_bit_ok[win[2:0]]))
        else $error("source served twice without end of service");
    a_poll_sets_is: assert property (rd_poll && win[3] |=>
        is_reg[$past(win[2:0])] && rdata[npi_pkg::POLL_VALID])
        else $error("poll read did not acknowledge");
    a_pstat_quiet: assert property (rd_pstat && !acknowledge_cycle |=>
        is_reg == ($past(is_reg) | '0) || $past(|take_v) == 1'b0
        && is_reg == $past(is_reg))
        else $error("poll status read changed in-service");
    a_eoi_clears: assert property (wr_eoi && !take |=>
        (is_reg & $past(eoi_clr)) == '0)
        else $error("end of service left flag set");
    a_casc_two_acks: assert property (ack_idle && win_casc |=>
        !vec_valid ##0 st_reg == npi_pkg::ST_CASC)
        else $error("cascaded source answered on first acknowledge");
    a_casc_vector: assert property (st_reg == npi_pkg::ST_CASC &&
        acknowledge_cycle |=> vec_valid && vec_type == $past(xv_s2_reg))
        else $error("external vector not returned");
    a_ack_pin_map: assert property (st_reg == npi_pkg::ST_CASC |->
        ext_request_c_or_ack_a_out == pair_reg)
        else $error("acknowledge on wrong pin");
    a_casc_disables_c: assert property (cas_a |->
        !pend[npi_pkg::SRC_EXC])
        else $error("pin c used as request in cascade");
    a_mask_blocks: assert property (win[3] |->
        !ctl_reg[win[2:0]].msk && raw_req[win[2:0]])
        else $error("masked source pending");
endmodule

`default_nettype wire

// ===== tb/npi_ext_ctl.sv
// Model of an external cascaded controller on request pair a
`default_nettype none

module npi_ext_ctl #(
    parameter logic [7:0] VEC = 8'h5A
) (
    input wire logic clock,
    input wire logic fire,
    input wire logic ack,
    output logic req,
    output logic [7:0] vector
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] junk = 8'h00;

    initial req = 1'b0;

    always @(posedge clock) begin
        junk <= junk + 8'h3B;
        // Request stays high until the acknowledge pin answers
        if (fire && !ack) req <= 1'b1;
        if (ack) req <= 1'b0;
    end

    // Released bus shows a moving pattern that steps by 8'h3B through every value, VEC included
    assign vector = ack ? VEC : junk;
endmodule

`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the nested priority interrupt unit
`default_nettype none

module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clock, rst, ack, nmi_pin, fire, rd_q;
    npi_pkg::npi_bus_s bus;
    logic [15:0] rdata;
    logic [2:0] timer_irq, l0, l1;
    logic [1:0] dma_irq;
    logic c_out, c_oe, d_out, d_oe, cpu_intr, cpu_nmi, vec_valid;
    logic [7:0] vec_type, ext_vector;
    logic req_a, req_b, pin_c, pin_d;
    logic [15:0] expq [$];
    int miscompares = 0;
    int n_checks = 0;
    int seed = 32'h3CB2;

    // Released pins are pulled low, so no phantom request
    assign pin_c = c_oe ? c_out : 1'b0;
    assign pin_d = d_oe ? d_out : 1'b0;

    npi_unit npi_unit_i (.clock(clock), .rst(rst), .bus(bus), .rdata(rdata),
        .timer_irq(timer_irq), .dma_irq(dma_irq), .ext_request_a(req_a),
        .ext_request_b(req_b), .ext_request_c_or_ack_a_in(pin_c),
        .ext_request_c_or_ack_a_out(c_out), .ext_request_c_or_ack_a_oe(c_oe),
        .ext_request_d_or_ack_b_in(pin_d),
        .ext_request_d_or_ack_b_out(d_out), .ext_request_d_or_ack_b_oe(d_oe),
        .nmi_pin(nmi_pin), .ext_vector(ext_vector),
        .acknowledge_cycle(ack), .cpu_intr(cpu_intr), .cpu_nmi(cpu_nmi),
        .vec_valid(vec_valid), .vec_type(vec_type));

    npi_ext_ctl npi_ext_ctl_i (.clock(clock), .fire(fire), .ack(pin_c),
        .req(req_a), .vector(ext_vector));

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic pop(input logic [15:0] seen);
        if (expq.size() == 0) begin
            miscompares++;
            $display("[FAIL] %0t result with nothing expected", $time);
        end else begin
            check(seen, expq.pop_front());
        end
    endtask

    // Read data and vectors stand one cycle: look mid-cycle
    always @(posedge clock) rd_q <= bus.rd;
    always @(negedge clock) begin
        if (rd_q === 1'b1) pop(rdata);
        if (vec_valid === 1'b1) pop({8'h00, vec_type});
    end

    function automatic logic [5:0] ctl(input int i);
        return npi_pkg::OFS_CTL0 + 6'(4 * i);
    endfunction

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clock);
        bus <= {a, d, 1'b1, 1'b0};
        @(posedge clock);
        bus.wr <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] a, input logic [15:0] exp);
        expq.push_back(exp);
        @(posedge clock);
        bus <= {a, 16'h0000, 1'b0, 1'b1};
        @(posedge clock);
        bus.rd <= 1'b0;
    endtask

    task automatic ack_pulse;
        @(posedge clock);
        ack <= 1'b1;
        @(posedge clock);
        ack <= 1'b0;
    endtask

    task automatic pulse_src(input logic [2:0] t, input logic [1:0] d);
        @(posedge clock);
        timer_irq <= t;
        dma_irq <= d;
        @(posedge clock);
        timer_irq <= 3'h0;
        dma_irq <= 2'h0;
    endtask

    // Bounded wait, pin requests need several cycles to sync
    task automatic wait_intr(input logic lvl);
        int i;
        for (i = 0; i < 20; i++) begin
            if (cpu_intr === lvl) break;
            @(negedge clock);
        end
        check({15'h0000, cpu_intr}, {15'h0000, lvl});
    endtask

    task automatic done(input string name);
        repeat (3) @(posedge clock);
        $display("test %s done", name);
    endtask

    task automatic tally_and_finish;
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        #(5000 * 8);
        miscompares++;
        tally_and_finish;
    end

    initial begin
        bus = '0;
        timer_irq = 3'h0;
        dma_irq = 2'h0;
        ack = 1'b0;
        nmi_pin = 1'b0;
        fire = 1'b0;
        req_b = 1'b0;
        rst = 1'b1;
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        for (int i = 0; i < 7; i++) rd(ctl(i), 16'h000F);
        rd(npi_pkg::OFS_MASK, 16'h007F);
        rd(npi_pkg::OFS_INSV, 16'h0000);
        rd(6'h3C, 16'h0000);
        done("reset");

        wr(ctl(1), 16'h0002);
        wr(ctl(2), 16'h0002);
        pulse_src(3'h0, 2'h3);
        wait_intr(1'b1);
        rd(npi_pkg::OFS_PSTAT, 16'h800A);
        rd(npi_pkg::OFS_INSV, 16'h0000);
        rd(npi_pkg::OFS_POLL, 16'h800A);
        rd(npi_pkg::OFS_INSV, 16'h0002);
        wait_intr(1'b0);
        wr(npi_pkg::OFS_EOI, 16'h8000);
        rd(npi_pkg::OFS_INSV, 16'h0000);
        rd(npi_pkg::OFS_POLL, 16'h800B);
        done("poll");

        wr(ctl(0), 16'h0001);
        pulse_src(3'h4, 2'h0);
        wait_intr(1'b1);
        expq.push_back(16'h0008);
        ack_pulse;
        rd(npi_pkg::OFS_INSV, 16'h0005);
        wr(npi_pkg::OFS_EOI, 16'h8000);
        rd(npi_pkg::OFS_INSV, 16'h0004);
        wr(npi_pkg::OFS_EOI, 16'h000B);
        rd(npi_pkg::OFS_INSV, 16'h0000);
        done("nesting");

        for (int k = 0; k < 4; k++) begin
            l0 = 3'($random(seed));
            l1 = 3'($random(seed));
            wr(ctl(0), {13'h0000, l0});
            wr(ctl(1), {13'h0000, l1});
            wr(npi_pkg::OFS_REQ, 16'h0003);
            rd(npi_pkg::OFS_PSTAT, (l0 <= l1) ? 16'h8008 : 16'h800A);
        end
        wr(npi_pkg::OFS_MASK, 16'h007F);
        repeat (4) @(negedge clock);
        check({15'h0000, cpu_intr}, 16'h0000);
        rd(ctl(0), {12'h000, 1'b1, l0});
        wr(npi_pkg::OFS_REQ, 16'h0000);
        done("levels");

        wr(ctl(3), 16'h0030);
        @(posedge clock) fire <= 1'b1;
        @(posedge clock) fire <= 1'b0;
        wait_intr(1'b1);
        ack_pulse;
        #1;
        check({14'h0000, c_oe, c_out}, 16'h0003);
        check({14'h0000, d_oe, d_out}, 16'h0000);
        repeat (2) @(posedge clock);
        expq.push_back(16'h005A);
        ack_pulse;
        wr(npi_pkg::OFS_EOI, 16'h8000);
        rd(npi_pkg::OFS_INSV, 16'h0000);
        done("cascade");

        // Pin b: edge sensed, special nested
        wr(ctl(4), 16'h0041);
        @(posedge clock) req_b <= 1'b1;
        wait_intr(1'b1);
        expq.push_back(16'h000D);
        ack_pulse;
        repeat (4) @(negedge clock);
        check({15'h0000, cpu_intr}, 16'h0000);
        @(posedge clock) req_b <= 1'b0;
        repeat (4) @(posedge clock);
        req_b <= 1'b1;
        wait_intr(1'b1);
        rd(npi_pkg::OFS_INSV, 16'h0010);
        wr(npi_pkg::OFS_INSV, 16'h0000);
        @(posedge clock) req_b <= 1'b0;
        done("special nested");

        @(posedge clock) nmi_pin <= 1'b1;
        repeat (5) @(negedge clock);
        check({15'h0000, cpu_nmi}, 16'h0001);
        @(posedge clock) nmi_pin <= 1'b0;
        done("nmi");

        wr(npi_pkg::OFS_RELOC, 16'h4000);
        rd(npi_pkg::OFS_RELOC, 16'h4000);
        @(negedge clock);
        check({15'h0000, c_oe}, 16'h0000);
        done("slave");
        check(16'(expq.size()), 16'h0000);
        tally_and_finish;
    end
endmodule

`default_nettype wire
